/* rtl/interval_timer.sv */
// Byte-wide host access, latching and three counting channels.
`timescale 1ns/100ps
`include "timer_defines.svh"
module interval_timer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_sel_lo,
  input wire logic port_sel_hi,
  input wire timer_pkg::byte_t data_in,
  output timer_pkg::byte_t data_out,
  output logic data_oe,
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  output logic [2:0] cnt_out
);
  import timer_pkg::*;

  logic [`PIN_W-1:0] pin_s1_q;
  logic [`PIN_W-1:0] pin_s2_q;
  logic [`PIN_W-1:0] pin_s3_q;
  logic [`PIN_W-1:0] pin_q;
  logic [`NUM_CNT-1:0] cclk_prev_q;

  logic wr_act;
  logic wr_act_q;
  logic wr_end;
  logic [1:0] cap_addr_q;
  byte_t cap_data_q;
  logic rd_act;
  logic rd_act_q;
  logic rd_start;
  logic rd_end;
  logic [1:0] rd_addr_q;
  logic [1:0] pin_addr;

  op_mode_t mode_q [`NUM_CNT];
  byte_access_t acc_q [`NUM_CNT];
  logic [`NUM_CNT-1:0] bcd_q;
  logic [`NUM_CNT-1:0] wr_ptr_q;
  logic [`NUM_CNT-1:0] rd_ptr_q;
  byte_t lsb_q [`NUM_CNT];
  logic [`NUM_CNT-1:0] cfg_stb_q;
  logic [`NUM_CNT-1:0] load_stb_q;
  logic [`NUM_CNT-1:0] halt_stb_q;
  count_t load_val_q [`NUM_CNT];
  count_t latch_q [`NUM_CNT];
  logic [`NUM_CNT-1:0] latch_valid_q;
  count_t live_count [`NUM_CNT];
  byte_t data_out_q;
  logic data_oe_q;

  logic [`NUM_CNT-1:0] ctrl_hit;
  logic [`NUM_CNT-1:0] cnt_wr;
  logic [`NUM_CNT-1:0] rd_done;
  byte_access_t cw_acc;

  // Picks the byte a read returns from the pointer and access setting.
  function automatic byte_t pick_byte(input byte_access_t a,
      input logic ptr, input count_t v);
    byte_t b;
    b = v[`CNT_LSB_HI:`CNT_LSB_LO];
    if (a == ACC_MSB || (a == ACC_BOTH && ptr)) begin
      b = v[`CNT_MSB_HI:`CNT_MSB_LO];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pins are asynchronous; a bit changes only once stages two and three
  // agree, so a glitch shorter than a clock never reaches the logic.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_s1_q <= `PIN_RST;
      pin_s2_q <= `PIN_RST;
      pin_s3_q <= `PIN_RST;
      pin_q <= `PIN_RST;
      cclk_prev_q <= '0;
    end else begin
      pin_s1_q <= {cnt_gate, cnt_clk, chip_sel_n, rd_n, wr_n,
                   port_sel_hi, port_sel_lo, data_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) |
               (pin_q & (pin_s2_q ^ pin_s3_q));
      cclk_prev_q <= pin_q[`PIN_CCLK_HI:`PIN_CCLK_LO];
    end
  end

  assign pin_addr = pin_q[`PIN_SEL_HI:`PIN_SEL_LO];
  assign wr_act = !pin_q[`PIN_WR] && !pin_q[`PIN_CS];
  assign rd_act = !pin_q[`PIN_RD] && !pin_q[`PIN_CS];
  assign wr_end = wr_act_q && !wr_act;
  assign rd_start = rd_act && !rd_act_q;
  assign rd_end = rd_act_q && !rd_act;
  assign cw_acc = byte_access_t'(cap_data_q[`CW_ACC_HI:`CW_ACC_LO]);

  ////////////////////////////////////////////////////////////////////////
  // Write data and address are sampled throughout the strobe and acted on when
  // it ends, because the data hold after the strobe is far below a cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      cap_addr_q <= '0;
      cap_data_q <= '0;
      rd_addr_q <= '0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        cap_addr_q <= pin_addr;
        cap_data_q <= pin_q[`PIN_DATA_HI:`PIN_DATA_LO];
      end
      if (rd_start) begin
        rd_addr_q <= pin_addr;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_CNT; i++) begin
      // Select code 11 matches no counter and is dropped. [RULE_18]
      ctrl_hit[i] = wr_end && cap_addr_q == `PORT_CTRL &&
        cap_data_q[`CW_SEL_HI:`CW_SEL_LO] == 2'(i); // [RULE_02]
      cnt_wr[i] = wr_end && cap_addr_q == 2'(i); // [RULE_04]
      rd_done[i] = rd_end && rd_addr_q == 2'(i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `NUM_CNT; i++) begin
      if (sys_rst) begin
        mode_q[i] <= `MODE_ZERO;
        acc_q[i] <= byte_access_t'(`ACC_RESET);
        bcd_q[i] <= 1'b0;
        cfg_stb_q[i] <= 1'b0;
      end else begin
        cfg_stb_q[i] <= 1'b0;
        if (ctrl_hit[i] && cw_acc != ACC_LATCH) begin
          mode_q[i] <= cap_data_q[`CW_MODE_HI:`CW_MODE_LO];
          acc_q[i] <= cw_acc; // [RULE_15]
          bcd_q[i] <= cap_data_q[`CW_BCD];
          cfg_stb_q[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count bytes are assembled per counter, so writes to other counters
  // may fall between the two bytes of one counter.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `NUM_CNT; i++) begin
      if (sys_rst) begin
        wr_ptr_q[i] <= 1'b0;
        lsb_q[i] <= '0;
        load_stb_q[i] <= 1'b0;
        halt_stb_q[i] <= 1'b0;
        load_val_q[i] <= '0;
      end else begin
        load_stb_q[i] <= 1'b0;
        halt_stb_q[i] <= 1'b0;
        if (ctrl_hit[i] && cw_acc != ACC_LATCH) begin
          wr_ptr_q[i] <= 1'b0; // [RULE_19]
        end else if (cnt_wr[i]) begin
          case (acc_q[i]) // [RULE_15]
            ACC_LSB: begin
              load_val_q[i] <= {`BYTE_ZERO, cap_data_q};
              load_stb_q[i] <= 1'b1;
            end
            ACC_MSB: begin
              load_val_q[i] <= {cap_data_q, `BYTE_ZERO};
              load_stb_q[i] <= 1'b1;
            end
            ACC_BOTH: begin
              if (!wr_ptr_q[i]) begin
                lsb_q[i] <= cap_data_q;
                wr_ptr_q[i] <= 1'b1;
                halt_stb_q[i] <= (mode_q[i] == `MODE_ZERO); // [RULE_17]
              end else begin
                load_val_q[i] <= {cap_data_q, lsb_q[i]}; // [RULE_07]
                load_stb_q[i] <= 1'b1;
                wr_ptr_q[i] <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The latch copies the live count and never touches the mode registers.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `NUM_CNT; i++) begin
      if (sys_rst) begin
        latch_q[i] <= '0;
        latch_valid_q[i] <= 1'b0;
        rd_ptr_q[i] <= 1'b0;
      end else if (ctrl_hit[i] && cw_acc != ACC_LATCH) begin
        latch_valid_q[i] <= 1'b0;
        rd_ptr_q[i] <= 1'b0; // [RULE_19]
      end else if (ctrl_hit[i] && !latch_valid_q[i]) begin
        latch_q[i] <= live_count[i]; // [RULE_12] [RULE_13]
        latch_valid_q[i] <= 1'b1; // [RULE_20]
      end else if (rd_done[i]) begin
        if (acc_q[i] == ACC_BOTH && !rd_ptr_q[i]) begin
          rd_ptr_q[i] <= 1'b1; // [RULE_10]
        end else begin
          rd_ptr_q[i] <= 1'b0;
          latch_valid_q[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The control port is never driven onto the data bus.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_out_q <= '0;
      data_oe_q <= 1'b0;
    end else begin
      data_oe_q <= rd_act && pin_addr != `PORT_CTRL; // [RULE_08]
      if (rd_start && pin_addr != `PORT_CTRL) begin
        data_out_q <= pick_byte(acc_q[pin_addr], rd_ptr_q[pin_addr],
          latch_valid_q[pin_addr] ? latch_q[pin_addr] :
          live_count[pin_addr]); // [RULE_08] [RULE_10] [RULE_12]
      end
    end
  end

  assign data_out = data_out_q;
  assign data_oe = data_oe_q;

  ////////////////////////////////////////////////////////////////////////
  count_bus_if ch_if [`NUM_CNT] ();

  for (genvar g = 0; g < `NUM_CNT; g++) begin : gen_ch
    assign ch_if[g].cfg_stb = cfg_stb_q[g];
    assign ch_if[g].load_stb = load_stb_q[g];
    assign ch_if[g].halt_stb = halt_stb_q[g];
    assign ch_if[g].load_val = load_val_q[g];
    assign ch_if[g].mode = mode_q[g];
    assign ch_if[g].bcd = bcd_q[g];
    assign ch_if[g].clk_rise =
      pin_q[`PIN_CCLK_LO + g] && !cclk_prev_q[g];
    assign ch_if[g].clk_fall =
      !pin_q[`PIN_CCLK_LO + g] && cclk_prev_q[g];
    assign ch_if[g].gate = pin_q[`PIN_GATE_LO + g];
    assign live_count[g] = ch_if[g].count;
    assign cnt_out[g] = ch_if[g].out;

    count_channel u_ch (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .bus(ch_if[g].chan)
    );
  end
endmodule

/* include/timer_defines.svh */
// Constants for the three-channel interval timer host-access logic.
// What this block and its host must do
// RULE_01: Host writes control word, then count bytes.
// RULE_02: Control words accepted in any counter order.
// RULE_03: Host loads bytes in programmed order.
// RULE_04: Count bytes accepted any time, interleaved.
// RULE_05: Counters only count downward.
// RULE_06: Zero count means maximum count.
// RULE_07: Mode 0 restarts only after full load.
// RULE_08: Address selects counter; address 11 unreadable.
// RULE_09: Host stops counter for direct reads.
// RULE_10: Two-byte read returns low then high.
// RULE_11: Host finishes reads before writing counts.
// RULE_12: Latch command holds count for reads.
// RULE_13: Latch ignores low bits, keeps mode.
// RULE_14: Host reads whole latched value first.
// RULE_15: Byte-access field decodes MSB, LSB, both.
// RULE_16: Count loads after counter clock rise, fall.
// RULE_17: Mode 0: first byte halts, second starts.
// RULE_18: Counter select code 11 is ignored.
// RULE_19: Per-counter byte pointers reset by control word.
// RULE_20: Pending latch blocks further latch commands.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define NUM_CNT 3
`define PORT_CTRL 2'h3
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_ACC_HI 5
`define CW_ACC_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD 0
`define MODE_ZERO 3'h0
`define CNT_ONE 16'h0001
`define BYTE_ZERO 8'h00
`define NIB_ZERO 4'h0
`define NIB_NINE 4'h9
`define NIB_ONE 4'h1
`define ACC_RESET 2'h1
`define NIB_W 4
`define NUM_NIB 4
`define CNT_LSB_HI 7
`define CNT_LSB_LO 0
`define CNT_MSB_HI 15
`define CNT_MSB_LO 8
`define MODE_RELOAD 1
`define MODE_FREE 0

// Layout of the synchronised pin vector.
`define PIN_W 19
`define PIN_DATA_HI 7
`define PIN_DATA_LO 0
`define PIN_SEL_LO 8
`define PIN_SEL_HI 9
`define PIN_WR 10
`define PIN_RD 11
`define PIN_CS 12
`define PIN_CCLK_HI 15
`define PIN_CCLK_LO 13
`define PIN_GATE_HI 18
`define PIN_GATE_LO 16
`define PIN_RST 19'h01c00

`endif

/* include/timer_pkg.sv */
// Types shared by the interval timer modules.
package timer_pkg;
  typedef enum logic [1:0] {
    ACC_LATCH,
    ACC_LSB,
    ACC_MSB,
    ACC_BOTH
  } byte_access_t;
  typedef logic [2:0] op_mode_t;
  typedef logic [15:0] count_t;
  typedef logic [7:0] byte_t;
endpackage

/* include/count_bus_if.sv */
// Carrier between the access logic and one counting channel.
`timescale 1ns/100ps
interface count_bus_if;
  import timer_pkg::*;
  logic cfg_stb;
  logic load_stb;
  logic halt_stb;
  count_t load_val;
  op_mode_t mode;
  logic bcd;
  logic clk_rise;
  logic clk_fall;
  logic gate;
  count_t count;
  logic out;
  modport host(output cfg_stb, output load_stb, output halt_stb,
    output load_val, output mode, output bcd, output clk_rise,
    output clk_fall, output gate, input count, input out);
  modport chan(input cfg_stb, input load_stb, input halt_stb,
    input load_val, input mode, input bcd, input clk_rise,
    input clk_fall, input gate, output count, output out);
endinterface

/* rtl/count_channel.sv */
// One down-counting channel with deferred count loading.
`timescale 1ns/100ps
`include "timer_defines.svh"
module count_channel (
  input wire logic clk_sys,
  input wire logic sys_rst,
  count_bus_if.chan bus
);
  import timer_pkg::*;

  count_t count_q;
  count_t reload_q;
  logic pend_q;
  logic armed_q;
  logic run_q;
  logic out_q;

  // Decimal wrap from 0000 to 9999 gives the full 10000 span for zero.
  function automatic count_t dec_count(input count_t v, input logic bcd);
    count_t r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - `CNT_ONE;
    end else begin
      for (int n = 0; n < `NUM_NIB; n++) begin
        if (borrow) begin
          if (v[n*`NIB_W +: `NIB_W] == `NIB_ZERO) begin
            r[n*`NIB_W +: `NIB_W] = `NIB_NINE;
          end else begin
            r[n*`NIB_W +: `NIB_W] = v[n*`NIB_W +: `NIB_W] - `NIB_ONE;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  function automatic logic periodic(input op_mode_t m);
    return m[`MODE_RELOAD];
  endfunction

  assign bus.count = count_q;
  assign bus.out = out_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reload_q <= '0;
      pend_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (bus.cfg_stb) begin
      pend_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (bus.load_stb) begin
      reload_q <= bus.load_val;
      pend_q <= 1'b1;
      armed_q <= 1'b0;
    end else if (pend_q && bus.clk_rise) begin
      armed_q <= 1'b1; // [RULE_16]
    end else if (pend_q && armed_q && bus.clk_fall) begin
      pend_q <= 1'b0; // [RULE_16]
      armed_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gate triggering of modes 1 and 5 is not modelled; those modes run free.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q <= '0;
      run_q <= 1'b0;
      out_q <= 1'b1;
    end else if (bus.cfg_stb) begin
      run_q <= 1'b0;
      out_q <= (bus.mode != `MODE_ZERO);
    end else if (bus.halt_stb) begin
      run_q <= 1'b0; // [RULE_17]
    end else if (pend_q && armed_q && bus.clk_fall) begin
      count_q <= reload_q; // [RULE_07] [RULE_17]
      run_q <= 1'b1;
      if (bus.mode == `MODE_ZERO) begin
        out_q <= 1'b0;
      end
    end else if (run_q && bus.clk_fall &&
        (bus.gate || bus.mode[`MODE_FREE])) begin
      count_q <= dec_count(count_q, bus.bcd); // [RULE_05] [RULE_06]
      if (bus.mode == `MODE_ZERO) begin
        if (count_q == `CNT_ONE) begin
          out_q <= 1'b1;
        end
      end else if (count_q == `CNT_ONE) begin
        out_q <= 1'b0;
        if (periodic(bus.mode)) begin
          count_q <= reload_q;
        end
      end else begin
        out_q <= 1'b1;
      end
    end
  end
endmodule

/* verification/interval_timer_checker.sv */
// Concurrent checks on the interval timer's bus and counter pins.
`timescale 1ns/100ps
module interval_timer_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_sel_lo,
  input wire logic port_sel_hi,
  input wire timer_pkg::byte_t data_in,
  input wire timer_pkg::byte_t data_out,
  input wire logic data_oe,
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  input wire logic [2:0] cnt_out
);
  import timer_pkg::*;
  // Strobes cross a pin synchroniser, so answers are judged cycles later.
  wire logic rd_ok = !rd_n && !chip_sel_n && !(port_sel_lo && port_sel_hi);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  //////////////////////////////
  reset_outputs_a: assert property (disable iff (1'b0)
    sys_rst |=> !data_oe && data_out == 8'h00 && cnt_out == 3'h7)
    else $error("outputs left reset values");
  read_cause_a: assert property ($rose(data_oe) |->
    $past(rd_ok, 3) && wr_n) else $error("bus driven without a read");
  ctrl_unread_a: assert property (
    $fell(rd_n) && !chip_sel_n && port_sel_lo && port_sel_hi |->
    !data_oe [*8]) else $error("control port answered a read");
  read_answer_a: assert property (rd_ok [*7] |-> data_oe)
    else $error("read not answered in time");
  read_release_a: assert property (rd_n [*7] |-> !data_oe)
    else $error("bus held after read");
  data_hold_a: assert property (data_oe && $past(data_oe) |->
    $stable(data_out)) else $error("read byte moved while driven");
  write_quiet_a: assert property (
    (!wr_n && !chip_sel_n) [*6] |-> !data_oe)
    else $error("bus driven during write");
  out_quiet_a: assert property (
    (wr_n && $stable(cnt_clk)) [*8] |-> $stable(cnt_out))
    else $error("counter output moved without cause");
endmodule
bind interval_timer interval_timer_checker chk_u (.clk_sys, .sys_rst,
  .chip_sel_n, .rd_n, .wr_n, .port_sel_lo, .port_sel_hi, .data_in,
  .data_out, .data_oe, .cnt_clk, .cnt_gate, .cnt_out);

/* verification/host_bus_model.sv */
// Byte-wide host processor model that drives the timer's bus pins.
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clk_sys,
  input wire timer_pkg::byte_t data_out,
  input wire logic data_oe,
  output logic chip_sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_sel_lo,
  output logic port_sel_hi,
  output timer_pkg::byte_t data_in
);
  import timer_pkg::*;
  byte_t seen;
  logic oe;
  initial begin
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {port_sel_hi, port_sel_lo} = 2'h0;
    data_in = 8'h00;
  end
  //////////////////////////////
  // Eight-cycle strobes and gaps leave room for the pin synchroniser.
  task automatic strobe(input logic [1:0] p, input logic rd, input byte_t b);
    @(posedge clk_sys);
    chip_sel_n <= 1'b0;
    {port_sel_hi, port_sel_lo} <= p;
    data_in <= rd ? ~data_in : b;
    if (rd) rd_n <= 1'b0; else wr_n <= 1'b0;
    repeat (7) @(posedge clk_sys);
    @(negedge clk_sys);
    seen = data_out;
    oe = data_oe;
    @(posedge clk_sys);
    chip_sel_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~data_in;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

/* verification/interval_timer_tb.sv */
// Self-checking bench for the interval timer host access.
`timescale 1ns/100ps
module interval_timer_tb;
  import timer_pkg::*;
  logic clk_sys, sys_rst, chip_sel_n, rd_n, wr_n, port_sel_lo, port_sel_hi;
  logic data_oe;
  byte_t data_in, data_out;
  logic [2:0] cnt_clk, cnt_gate, cnt_out, out_m;
  logic [15:0] r;
  integer seed = 91525;
  int n_errors = 0;
  int tests_run = 0;
  int cnt[3], acc[3], rp[3], wp[3], lat[3], latv[3], pend[3], pv[3], run[3];
  int md[3], bcd[3];
  interval_timer dut_u (.clk_sys, .sys_rst, .chip_sel_n, .rd_n, .wr_n,
    .port_sel_lo, .port_sel_hi, .data_in, .data_out, .data_oe, .cnt_clk,
    .cnt_gate, .cnt_out);
  host_bus_model host_u (.clk_sys, .data_out, .data_oe, .chip_sel_n, .rd_n,
    .wr_n, .port_sel_lo, .port_sel_hi, .data_in);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  //////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Decimal step of the model: four packed digits, 0000 wraps to 9999.
  function automatic int bcd_dec(input int v);
    int d, r;
    d = 0;
    r = 0;
    for (int n = 12; n >= 0; n -= 4) begin
      d = d * 10 + (v >> n) % 16;
    end
    d = (d + 9999) % 10000;
    for (int n = 1000; n > 0; n /= 10) begin
      r = r * 16 + d / n % 10;
    end
    return r;
  endfunction
  // The low nibble d carries the mode bits and the decimal bit.
  task automatic cw(input int c, input int a, input int d = 0);
    host_u.strobe(2'h3, 1'b0, byte_t'(c * 64 + a * 16 + d));
    acc[c] = a;
    md[c] = d / 2;
    bcd[c] = d % 2;
    rp[c] = 0;
    wp[c] = 0;
    lat[c] = 0;
    pend[c] = 0;
    run[c] = 0;
    out_m[c] = (d / 2 != 0);
  endtask
  task automatic latch(input int c, input int lo);
    host_u.strobe(2'h3, 1'b0, byte_t'(c * 64 + lo));
    if (!lat[c]) latv[c] = cnt[c];
    lat[c] = 1;
  endtask
  task automatic wb(input int c, input byte_t b);
    host_u.strobe(c[1:0], 1'b0, b);
    if (acc[c] == 3 && wp[c] == 0) begin
      pv[c] = b;
      wp[c] = 1;
    end else begin
      pv[c] = acc[c] == 1 ? b : (acc[c] == 2 ? b * 256 : pv[c] + b * 256);
      wp[c] = 0;
      pend[c] = 1;
    end
  endtask
  task automatic rdb(input int c);
    int v, e;
    v = lat[c] ? latv[c] : cnt[c];
    e = (acc[c] == 2 || (acc[c] == 3 && rp[c] == 1)) ? v / 256 : v % 256;
    if (acc[c] == 3) rp[c] = 1 - rp[c];
    if (rp[c] == 0) lat[c] = 0;
    host_u.strobe(c[1:0], 1'b1, 8'h00);
    // Bit 8 of the expected word is the output enable during the read.
    e = e + 256;
    check("read byte", {7'h0, host_u.oe, host_u.seen}, 16'(e));
  endtask
  // Counter clocks move only inside tick, so direct reads see a still count.
  task automatic tick(input logic [2:0] m);
    @(posedge clk_sys);
    cnt_clk <= m;
    repeat (8) @(posedge clk_sys);
    cnt_clk <= 3'h0;
    repeat (8) @(posedge clk_sys);
    for (int c = 0; c < 3; c++) begin
      if (m[c] && pend[c]) begin
        cnt[c] = pv[c];
        pend[c] = 0;
        run[c] = 1;
        if (md[c] == 0) out_m[c] = 1'b0;
      end else if (m[c] && run[c] && !wp[c] && cnt_gate[c]) begin
        if (md[c] == 2) begin
          out_m[c] = (cnt[c] != 1);
          cnt[c] = cnt[c] == 1 ? pv[c] : (cnt[c] + 65535) % 65536;
        end else begin
          cnt[c] = bcd[c] ? bcd_dec(cnt[c]) : (cnt[c] + 65535) % 65536;
          out_m[c] = out_m[c] | (cnt[c] == 0);
        end
      end
    end
  endtask
  //////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    cnt_clk = 3'h0;
    cnt_gate = 3'h7;
    out_m = 3'h7;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check("reset state", {data_oe, 12'h0, cnt_out}, 16'h0007);
    $display("test reset done");
    cw(2, 3);
    cw(0, 1);
    cw(1, 2);
    check("mode outputs", 16'(cnt_out), 16'(out_m));
    r = 16'($random(seed));
    wb(2, r[7:0]);
    wb(0, 8'h03);
    wb(1, 8'h00);
    wb(2, r[15:8]);
    tick(3'h7);
    rdb(2);
    rdb(2);
    rdb(0);
    rdb(1);
    repeat (3) tick(3'h7);
    check("count outputs", 16'(cnt_out), 16'(out_m));
    rdb(2);
    rdb(2);
    rdb(1);
    rdb(0);
    $display("test load and count done");
    latch(2, 15);
    tick(3'h4);
    latch(2, 0);
    tick(3'h4);
    rdb(2);
    rdb(2);
    rdb(2);
    rdb(2);
    check("latch outputs", 16'(cnt_out), 16'(out_m));
    $display("test latch done");
    host_u.strobe(2'h3, 1'b1, 8'h00);
    check("control read", 16'(host_u.oe), 16'h0000);
    host_u.strobe(2'h3, 1'b0, 8'hd0);
    rdb(1);
    rdb(2);
    rdb(2);
    $display("test illegal codes done");
    rdb(2);
    cw(2, 3);
    r = 16'($random(seed)) | 16'h0100;
    wb(2, r[7:0]);
    tick(3'h4);
    tick(3'h4);
    rdb(2);
    rdb(2);
    wb(2, r[15:8]);
    tick(3'h4);
    rdb(2);
    rdb(2);
    check("restart outputs", 16'(cnt_out), 16'(out_m));
    $display("test restart done");
    cnt_gate <= 3'h3;
    tick(3'h7);
    rdb(2);
    rdb(2);
    cnt_gate <= 3'h7;
    cw(1, 3, 1);
    wb(1, 8'h00);
    wb(1, 8'h00);
    repeat (2) tick(3'h2);
    rdb(1);
    rdb(1);
    check("decimal outputs", 16'(cnt_out), 16'(out_m));
    cw(0, 1, 4);
    wb(0, 8'h02);
    repeat (3) begin
      tick(3'h1);
      check("rate outputs", 16'(cnt_out), 16'(out_m));
      rdb(0);
    end
    $display("test gate, decimal and rate done");
    end_of_test();
  end
endmodule
